// ### pewc_map.svh
// Register offsets, field positions, reset values and prescaler counts of the counter.
`ifndef PEWC_MAP_SVH
`define PEWC_MAP_SVH

`define PEWC_ADDR_W        4
`define PEWC_DATA_W        16
`define PEWC_ADDR_CTRL     4'h0
`define PEWC_ADDR_LIMIT    4'h1
`define PEWC_ADDR_CAPTURE  4'h2
`define PEWC_ADDR_COUNT    4'h3

`define PEWC_CTRL_RESET    16'h0000
`define PEWC_LIMIT_RESET   16'hFFFF
`define PEWC_CTRL_MASK     16'h01FF

`define PEWC_START_LO      0
`define PEWC_START_HI      1
`define PEWC_MODE_LO       2
`define PEWC_MODE_HI       3
`define PEWC_SRC_LO        4
`define PEWC_SRC_HI        5
`define PEWC_CAP_MODE_BIT  6
`define PEWC_ACAP_BIT      7
`define PEWC_WIN_NEG_BIT   8

`define PEWC_PRE_W         8
`define PEWC_DIV_SHIFT_0   7
`define PEWC_DIV_SHIFT_1   3
`define PEWC_DIV_SHIFT_2   1
`define PEWC_DIV_SHIFT_3   0

`endif

// ### pewc_pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses for the counter input pin.
`timescale 1ns/1ps

module pewc_pin_sync (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Pin and filtered view.
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic level_d;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else if (ce) begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change is accepted only once the last two stages agree.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level   <= 1'b0;
			level_d <= 1'b0;
		end else if (ce) begin
			if (stage2 == stage3) begin
				level <= stage2;
			end
			level_d <= level;
		end
	end

	assign rise = level & ~level_d;
	assign fall = ~level & level_d;

endmodule

// ### pewc_pkg.sv
// Types shared by the event and window counter design files.
package pewc_pkg;

	typedef enum logic [1:0] {
		pewc_start_stop = 2'h0,
		pewc_start_cmd  = 2'h1,
		pewc_start_rise = 2'h2,
		pewc_start_fall = 2'h3
	} pewc_start_type;

	typedef enum logic [1:0] {
		pewc_mode_event  = 2'h0,
		pewc_mode_window = 2'h1,
		pewc_mode_pulse  = 2'h2,
		pewc_mode_rsvd   = 2'h3
	} pewc_mode_type;

	typedef enum logic [1:0] {
		pewc_pm_wait,
		pewc_pm_first,
		pewc_pm_second
	} pewc_pm_state_type;

endpackage

// ### pewc_prescaler.sv
// Divider, held at zero while stopped, that yields the selected internal source clock as a one-cycle tick.
`timescale 1ns/1ps
`include "pewc_map.svh"

module pewc_prescaler #(
	parameter int PRE_W = `PEWC_PRE_W
) (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Control and tick.
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output logic            tick
);

	logic [PRE_W-1:0] div;
	logic [PRE_W-1:0] mask;

	always_comb begin
		unique case (sel)
			2'h0: mask = PRE_W'((1 << `PEWC_DIV_SHIFT_0) - 1);
			2'h1: mask = PRE_W'((1 << `PEWC_DIV_SHIFT_1) - 1);
			2'h2: mask = PRE_W'((1 << `PEWC_DIV_SHIFT_2) - 1);
			2'h3: mask = PRE_W'((1 << `PEWC_DIV_SHIFT_3) - 1);
		endcase
	end

	// Restarting from zero on every start keeps the first period full length.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= '0;
		end else if (ce) begin
			div <= run ? PRE_W'(div + 1'b1) : '0;
		end
	end

	assign tick = run & ((div & mask) == mask);

endmodule

// ### pewc_pulse_src.sv
// Behavioural external pulse source that drives the counter input pin.
`timescale 1ns/1ps

module pewc_pulse_src (
	// Clock.
	input  wire logic ref_clk,
	// Pin.
	output logic      pin
);
	logic idle;
	int   act_len;
	int   idle_len;

	initial begin
		idle = 1'b0;
		act_len = 20;
		idle_len = 20;
		pin = 1'b0;
	end

	// Lengths are never set below eight clocks, since shorter phases may be lost.
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			pin <= !idle;
			repeat (act_len) @(posedge ref_clk);
			pin <= idle;
			repeat (idle_len - 1) @(posedge ref_clk);
		end
	endtask

	task automatic park(input logic lvl);
		@(posedge ref_clk);
		idle = lvl;
		pin <= lvl;
	endtask
endmodule

// ### pewc_top.sv
// Sixteen-bit event, window and pulse-measurement counter with its register port.
`timescale 1ns/1ps
`include "pewc_map.svh"

module pewc_top #(
	parameter int DATA_W = `PEWC_DATA_W,
	parameter int ADDR_W = `PEWC_ADDR_W
) (
	// Clock, reset and clock enable.
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Register port.
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Power management and pin.
	input  wire logic              stop_mode_req,
	input  wire logic              counter_input_pin,
	// Interrupt request pulse.
	output logic                   counter_irq
);

	import pewc_pkg::*;

	logic              rst_meta_n;
	logic              rst_sync_n;
	logic [DATA_W-1:0] counter_control_reg;
	logic [DATA_W-1:0] compare_limit_reg;
	logic [DATA_W-1:0] capture_reg;
	logic [DATA_W-1:0] count;
	pewc_pm_state_type pm_state;
	pewc_start_type    start_edge_control;
	pewc_mode_type     mode;
	logic [1:0]        source_clock_select;
	logic              capture_edge_mode;
	logic              auto_capture_enable;
	logic              window_negative;
	logic              running;
	logic              pin_level;
	logic              pin_rise;
	logic              pin_fall;
	logic              src_tick;
	logic              act_edge;
	logic              opp_edge;
	logic              gate;
	logic              at_limit;
	logic              is_event;
	logic              is_window;
	logic              is_pulse;
	logic              ctrl_wr;

	// Reset is released through two flops so every process leaves reset on the same edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	pewc_pin_sync u_pin_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.ce      (ce),
		.pin_in  (counter_input_pin),
		.level   (pin_level),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	pewc_prescaler u_prescaler (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.ce      (ce),
		.run     (running),
		.sel     (source_clock_select),
		.tick    (src_tick)
	);

	assign start_edge_control  = pewc_start_type'(counter_control_reg[`PEWC_START_HI:`PEWC_START_LO]);
	assign mode                = pewc_mode_type'(counter_control_reg[`PEWC_MODE_HI:`PEWC_MODE_LO]);
	assign source_clock_select = counter_control_reg[`PEWC_SRC_HI:`PEWC_SRC_LO];
	assign capture_edge_mode   = counter_control_reg[`PEWC_CAP_MODE_BIT];
	assign auto_capture_enable = counter_control_reg[`PEWC_ACAP_BIT];
	assign window_negative     = counter_control_reg[`PEWC_WIN_NEG_BIT];

	assign running   = (start_edge_control != pewc_start_stop);
	assign is_event  = running && (mode == pewc_mode_event);
	assign is_window = running && (mode == pewc_mode_window);
	assign is_pulse  = running && (mode == pewc_mode_pulse);
	assign ctrl_wr   = reg_wr && (reg_addr == `PEWC_ADDR_CTRL);

	// Falling is chosen only by its own code; command start behaves as rising.
	assign act_edge = (start_edge_control == pewc_start_fall) ? pin_fall : pin_rise;
	assign opp_edge = (start_edge_control == pewc_start_fall) ? pin_rise : pin_fall;
	assign gate     = pin_level ^ window_negative;
	assign at_limit = (count == compare_limit_reg);

	// Stop-mode entry overrides a same-cycle software write so the counter is sure to halt.
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			counter_control_reg <= `PEWC_CTRL_RESET;
		end else if (ce) begin
			if (ctrl_wr) begin
				counter_control_reg <= reg_wdata & `PEWC_CTRL_MASK;
			end
			if (stop_mode_req) begin
				counter_control_reg[`PEWC_START_HI:`PEWC_START_LO] <= 2'h0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			compare_limit_reg <= `PEWC_LIMIT_RESET;
		end else if (ce && reg_wr && (reg_addr == `PEWC_ADDR_LIMIT)) begin
			compare_limit_reg <= reg_wdata;
		end
	end

	// Counter, measurement sequencer and interrupt pulse share one process.
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count       <= '0;
			pm_state    <= pewc_pm_wait;
			counter_irq <= 1'b0;
		end else if (ce) begin
			counter_irq <= 1'b0;
			if (!running) begin
				count    <= '0;
				pm_state <= pewc_pm_wait;
			end else if (is_event) begin
				if (opp_edge && at_limit) begin
					count       <= '0;
					counter_irq <= 1'b1;
				end else if (act_edge) begin
					count <= DATA_W'(count + 1'b1);
				end
			end else if (is_window) begin
				if (src_tick && gate) begin
					if (at_limit) begin
						count       <= '0;
						counter_irq <= 1'b1;
					end else begin
						count <= DATA_W'(count + 1'b1);
					end
				end
			end else if (is_pulse) begin
				unique case (pm_state)
					pewc_pm_wait: begin
						if (act_edge) begin
							pm_state <= pewc_pm_first;
						end
					end
					pewc_pm_first: begin
						if (opp_edge) begin
							counter_irq <= 1'b1;
							if (capture_edge_mode) begin
								count    <= DATA_W'(1);
								pm_state <= pewc_pm_wait;
							end else begin
								// A period measurement must not lose the tick of its mid-period capture.
								pm_state <= pewc_pm_second;
								if (src_tick) begin
									count <= DATA_W'(count + 1'b1);
								end
							end
						end else if (src_tick) begin
							count <= DATA_W'(count + 1'b1);
						end
					end
					pewc_pm_second: begin
						if (act_edge) begin
							count       <= '0;
							counter_irq <= 1'b1;
							pm_state    <= pewc_pm_first;
						end else if (src_tick) begin
							count <= DATA_W'(count + 1'b1);
						end
					end
				endcase
			end
		end
	end

	// Measurement captures take priority over auto-capture on the same edge.
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			capture_reg <= '0;
		end else if (ce) begin
			if (is_pulse && pm_state == pewc_pm_first && opp_edge) begin
				capture_reg <= count;
			end else if (is_pulse && pm_state == pewc_pm_second && act_edge) begin
				capture_reg <= count;
			end else if (running && auto_capture_enable && src_tick) begin
				capture_reg <= count;
			end
		end
	end

	// Read data stand for exactly one cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= '0;
		end else if (ce) begin
			if (reg_rd) begin
				unique case (reg_addr)
					`PEWC_ADDR_CTRL:    reg_rdata <= counter_control_reg;
					`PEWC_ADDR_LIMIT:   reg_rdata <= compare_limit_reg;
					`PEWC_ADDR_CAPTURE: reg_rdata <= capture_reg;
					`PEWC_ADDR_COUNT:   reg_rdata <= count;
					default:            reg_rdata <= '0;
				endcase
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_sync_n);

	property p_evt_inc;
		ce && is_event && act_edge && !ctrl_wr && !stop_mode_req
			|=> count == DATA_W'($past(count) + 1'b1);
	endproperty
	a_evt_inc: assert property (p_evt_inc) else $error("event count did not step");

	property p_evt_match;
		ce && is_event && opp_edge && at_limit && !ctrl_wr && !stop_mode_req
			|=> counter_irq && count == '0;
	endproperty
	a_evt_match: assert property (p_evt_match) else $error("event match missed");

	property p_evt_resume;
		(is_event && counter_irq) ##[1:1000] (is_event && count == 16'h0001);
	endproperty

	property p_evt_irq_cause;
		counter_irq && $past(is_event) |-> $past(opp_edge) && $past(at_limit);
	endproperty
	a_evt_irq_cause: assert property (p_evt_irq_cause) else $error("stray event irq");

	property p_acap;
		ce && running && auto_capture_enable && src_tick && !is_pulse
			|=> capture_reg == $past(count);
	endproperty
	a_acap: assert property (p_acap) else $error("auto-capture missed");

	property p_win_gate;
		ce && is_window && !gate && !ctrl_wr && !stop_mode_req |=> count == $past(count);
	endproperty
	a_win_gate: assert property (p_win_gate) else $error("window counted while closed");

	property p_win_step;
		ce && is_window && gate && src_tick && !at_limit && !ctrl_wr && !stop_mode_req
			|=> count == DATA_W'($past(count) + 1'b1);
	endproperty
	a_win_step: assert property (p_win_step) else $error("window count did not step");

	property p_win_match;
		ce && is_window && gate && src_tick && at_limit && !ctrl_wr && !stop_mode_req
			|=> counter_irq && count == '0;
	endproperty
	a_win_match: assert property (p_win_match) else $error("window match missed");

	property p_pm_single;
		ce && is_pulse && pm_state == pewc_pm_first && opp_edge && capture_edge_mode
			&& !ctrl_wr && !stop_mode_req
			|=> counter_irq && capture_reg == $past(count) && count == 16'h0001
				##1 (!ce || count == 16'h0001 || pm_state != pewc_pm_wait);
	endproperty
	a_pm_single: assert property (p_pm_single) else $error("single-edge capture wrong");

	property p_pm_hold;
		ce && is_pulse && pm_state == pewc_pm_wait && !act_edge && !ctrl_wr && !stop_mode_req
			|=> count == $past(count);
	endproperty
	a_pm_hold: assert property (p_pm_hold) else $error("counter moved while waiting");

	property p_pm_double;
		ce && is_pulse && pm_state == pewc_pm_second && act_edge && !ctrl_wr && !stop_mode_req
			|=> counter_irq && capture_reg == $past(count) && count == '0
				&& pm_state == pewc_pm_first;
	endproperty
	a_pm_double: assert property (p_pm_double) else $error("double-edge capture wrong");

	property p_pm_dbl_mid;
		ce && is_pulse && pm_state == pewc_pm_first && opp_edge && !capture_edge_mode && src_tick
			&& !ctrl_wr && !stop_mode_req
			|=> counter_irq && capture_reg == $past(count) && pm_state == pewc_pm_second
				&& count == DATA_W'($past(count) + 1'b1);
	endproperty
	a_pm_dbl_mid: assert property (p_pm_dbl_mid) else $error("double-edge mid capture wrong");

	property p_ce_hold;
		!ce |=> count == $past(count) && capture_reg == $past(capture_reg)
			&& counter_control_reg == $past(counter_control_reg);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");

	property p_stop_req;
		ce && stop_mode_req |=> !running ##1 (!ce || count == '0);
	endproperty
	a_stop_req: assert property (p_stop_req) else $error("stop mode did not halt");

	property p_stop_clear;
		ce && !running |=> count == '0 && !counter_irq;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not clear");

	c_evt_resume: cover property (p_evt_resume);
	c_win_irq:    cover property (is_window && counter_irq);
	c_pm_single:  cover property (is_pulse && capture_edge_mode && counter_irq);
	c_pm_double:  cover property (is_pulse && !capture_edge_mode && pm_state == pewc_pm_second
		&& act_edge);

endmodule

// ### testbench.sv
// Self-checking bench for the event, window and pulse-measurement counter.
`timescale 1ns/1ps
`include "pewc_map.svh"

module testbench;
	logic                    ref_clk;
	logic                    rst_n;
	logic                    ce;
	logic [`PEWC_ADDR_W-1:0] reg_addr;
	logic [15:0]             reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [15:0]             reg_rdata;
	logic                    stop_mode_req;
	logic                    pin;
	logic                    counter_irq;
	logic                    rd_d;
	logic                    lv;
	logic [15:0]             c1;
	logic [15:0]             c2;
	logic [15:0]             c3;
	logic [15:0]             lim;
	logic [15:0]             exp_q[$];
	string                   name_q[$];
	int                      error_cnt;
	int                      checks;
	int                      irq_seen;
	int                      cyc;
	int                      n0;
	int                      na;

	pewc_top pewc_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.stop_mode_req(stop_mode_req), .counter_input_pin(pin), .counter_irq(counter_irq));
	pewc_pulse_src pewc_pulse_src_i (.ref_clk(ref_clk), .pin(pin));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Read data are compared in the cycle after the strobe, the only cycle they stand.
	always @(posedge ref_clk) begin
		cyc++;
		if (counter_irq === 1'b1) irq_seen++;
		if (rd_d === 1'b1) begin
			if (name_q[0] != "") chk(name_q[0], exp_q[0], reg_rdata);
			void'(exp_q.pop_front());
			void'(name_q.pop_front());
		end else if (cyc > 2) begin
			chk("rdata idle", 16'h0000, reg_rdata);
		end
		rd_d = reg_rd;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic wr(input logic [`PEWC_ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [`PEWC_ADDR_W-1:0] a, input logic [15:0] e, input string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic rdv(input logic [`PEWC_ADDR_W-1:0] a, output logic [15:0] v);
		rd(a, 16'h0000, "");
		#1 v = reg_rdata;
	endtask

	// The capture is read at once, well before the next trigger edge can arrive.
	task automatic cap_next(output logic [15:0] v, output logic l);
		int k;
		k = 0;
		while (counter_irq !== 1'b1 && k < 400) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		l = pin;
		if (k == 400) chk("irq wait", 16'h0001, 16'h0000);
		rdv(`PEWC_ADDR_CAPTURE, v);
	endtask

	function automatic logic [15:0] cfg(input logic [1:0] st, input logic [1:0] md,
		input logic [1:0] src, input logic cm, input logic ac, input logic ng);
		return {7'h00, ng, ac, cm, src, md, st};
	endfunction

	// Configuration is written while stopped, then the start field is set.
	task automatic go(input logic [15:0] c);
		wr(`PEWC_ADDR_CTRL, c & 16'hFFFC);
		wr(`PEWC_ADDR_CTRL, c);
	endtask

	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		stop_mode_req = 1'b0;
		ce = 1'b1;
		rd_d = 1'b0;
		error_cnt = 0;
		checks = 0;
		irq_seen = 0;
		cyc = 0;
		void'($urandom(32'hF31E));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(`PEWC_ADDR_CTRL, 16'h0000, "ctrl reset");
		rd(`PEWC_ADDR_LIMIT, 16'hFFFF, "limit reset");
		rd(`PEWC_ADDR_CAPTURE, 16'h0000, "capture reset");
		rd(`PEWC_ADDR_COUNT, 16'h0000, "count reset");
		rd(4'h7, 16'h0000, "unmapped");
		lim = 16'($urandom);
		// The start field stays clear so no random mode is left running.
		wr(`PEWC_ADDR_CTRL, lim & 16'hFFFC);
		rd(`PEWC_ADDR_CTRL, lim & 16'h01FC, "ctrl mask");
		wr(`PEWC_ADDR_CTRL, 16'h0000);
		wr(`PEWC_ADDR_COUNT, 16'h1234);
		rd(`PEWC_ADDR_COUNT, 16'h0000, "count read only");
		for (int st = 1; st <= 3; st++) begin
			lim = 16'(3 + $urandom % 4);
			wr(`PEWC_ADDR_LIMIT, lim);
			pewc_pulse_src_i.park(st == 3);
			go(cfg(st[1:0], 2'h0, 2'h3, 1'b0, 1'b0, 1'b0));
			n0 = irq_seen;
			pewc_pulse_src_i.burst(int'(lim) + int'(st == 3));
			repeat (8) @(posedge ref_clk);
			chk("event irq", 16'(n0 + 1), 16'(irq_seen));
			rd(`PEWC_ADDR_COUNT, 16'(st == 3), "event clear");
			pewc_pulse_src_i.burst(2 - int'(st == 3));
			repeat (8) @(posedge ref_clk);
			rd(`PEWC_ADDR_COUNT, 16'h0002, "event resume");
		end
		wr(`PEWC_ADDR_LIMIT, 16'h0005);
		pewc_pulse_src_i.act_len = 14;
		for (int ng = 0; ng <= 1; ng++) begin
			pewc_pulse_src_i.park(ng[0]);
			// The half-rate source gives seven ticks in the fourteen-cycle gate.
			go(cfg(2'h1, 2'h1, ng[0] ? 2'h2 : 2'h3, 1'b0, 1'b0, ng[0]));
			n0 = irq_seen;
			pewc_pulse_src_i.burst(1);
			repeat (8) @(posedge ref_clk);
			chk("window irq", 16'(n0 + 2 - ng), 16'(irq_seen));
			rd(`PEWC_ADDR_COUNT, 16'(2 - ng), "window count");
		end
		pewc_pulse_src_i.act_len = 20;
		pewc_pulse_src_i.park(1'b0);
		go(cfg(2'h2, 2'h2, 2'h3, 1'b1, 1'b0, 1'b0));
		n0 = irq_seen;
		fork
			pewc_pulse_src_i.burst(3);
			begin
				cap_next(c1, lv);
				cap_next(c2, lv);
				cap_next(c3, lv);
			end
		join
		chk("single second capture", c1 + 16'h0001, c2);
		chk("single third capture", c2, c3);
		rd(`PEWC_ADDR_COUNT, 16'h0001, "single held count");
		chk("single irq", 16'(n0 + 3), 16'(irq_seen));
		pewc_pulse_src_i.idle_len = 30;
		for (int st = 2; st <= 3; st++) begin
			pewc_pulse_src_i.park(st == 3);
			go(cfg(st[1:0], 2'h2, 2'h3, 1'b0, 1'b0, 1'b0));
			na = 0;
			fork
				pewc_pulse_src_i.burst(5);
				for (int k = 0; k < 7; k++) begin
					cap_next(c2, lv);
					if (lv === pewc_pulse_src_i.idle) begin
						c1 = c2;
						na++;
					end else if (na > 1) begin
						chk("double idle phase", 16'h001E, c2 - c1);
					end
				end
			join
		end
		pewc_pulse_src_i.idle_len = 20;
		wr(`PEWC_ADDR_LIMIT, 16'h000A);
		pewc_pulse_src_i.park(1'b0);
		go(cfg(2'h2, 2'h0, 2'h1, 1'b0, 1'b1, 1'b0));
		pewc_pulse_src_i.burst(2);
		repeat (20) @(posedge ref_clk);
		rd(`PEWC_ADDR_CAPTURE, 16'h0002, "auto capture");
		// Pin edges and a register write made while the clock enable is low must be lost.
		@(posedge ref_clk);
		ce <= 1'b0;
		pewc_pulse_src_i.burst(1);
		wr(`PEWC_ADDR_LIMIT, 16'h0003);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd(`PEWC_ADDR_COUNT, 16'h0002, "ce freeze count");
		rd(`PEWC_ADDR_LIMIT, 16'h000A, "ce freeze limit");
		@(posedge ref_clk);
		stop_mode_req <= 1'b1;
		@(posedge ref_clk);
		stop_mode_req <= 1'b0;
		rd(`PEWC_ADDR_CTRL, cfg(2'h0, 2'h0, 2'h1, 1'b0, 1'b1, 1'b0), "stop ctrl");
		rd(`PEWC_ADDR_COUNT, 16'h0000, "stop clears");
		pewc_pulse_src_i.burst(1);
		repeat (8) @(posedge ref_clk);
		rd(`PEWC_ADDR_COUNT, 16'h0000, "stop halts");
		go(cfg(2'h2, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0));
		pewc_pulse_src_i.burst(1);
		rd(`PEWC_ADDR_COUNT, 16'h0000, "reserved mode holds");
		repeat (3) @(posedge ref_clk);
		tally_and_finish();
	end
endmodule
